// *** core/ppes_regs.sv ***
`timescale 1ns/1ps
module ppes_regs (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        config_checksum_fail_in,
  input  wire logic        config_load_aborted_in,
  input  wire logic        config_load_active_in,
  input  wire logic        init_finished_in,
  input  wire logic        load_relock_init_complete_in,
  input  wire logic        config_load_done_in,
  output logic             system_analog_loop_off,
  output logic             system_digital_loop_off,
  output logic             second_loop_off,
  output logic             first_loop_off,
  output logic             first_input_monitor_rst,
  output logic             second_input_monitor_rst,
  output logic             system_digital_loop_rst,
  output logic             first_digital_loop_rst,
  output logic             second_digital_loop_rst,
  output logic             serif_clk_from_osc,
  output logic             serif_osc_second,
  output logic             gpio_level_select,
  output logic             serial_out_level_select
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]                     pwr_ctrl_q;
  logic [7:0]                     pwr_ctrl_d;
  logic [ppes_pkg::STS_WIDTH-1:0] sts_q;
  logic [ppes_pkg::STS_WIDTH-1:0] sts_d;
  logic [2:0]                     io_level_q;
  logic [2:0]                     io_level_d;
  logic [7:0]                     rdata_q;
  logic [7:0]                     rdata_d;
  logic                           rvalid_q;
  logic [ppes_pkg::STS_WIDTH-1:0] evt_async;
  logic [ppes_pkg::STS_WIDTH-1:0] evt;

  // ****************************************************************
  // loader status inputs, resynchronised
  // ****************************************************************
  assign evt_async = {config_checksum_fail_in,
                      config_load_aborted_in,
                      config_load_active_in,
                      init_finished_in,
                      load_relock_init_complete_in,
                      config_load_done_in};

  ppes_sync #(
    .WIDTH (ppes_pkg::STS_WIDTH)
  ) u_ppes_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (evt_async),
    .sync_out (evt)
  );

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire hit_pwr = (reg_addr == ppes_pkg::PWR_CTRL_OFFSET);
  wire hit_sts = (reg_addr == ppes_pkg::LOAD_STS_OFFSET);
  wire hit_io  = (reg_addr == ppes_pkg::IO_LEVEL_OFFSET);
  wire wr_pwr  = reg_wr & hit_pwr;
  wire wr_io   = reg_wr & hit_io;

  // reserved power control bits are stored as written, io level keeps bits 2:0 only; software keeps them at zero
  assign pwr_ctrl_d = wr_pwr ? reg_wdata : pwr_ctrl_q;
  assign io_level_d = wr_io ? reg_wdata[2:0] : io_level_q;

  // ****************************************************************
  // status flags: no write path reaches them
  // ****************************************************************
  wire st_chk    = evt[ppes_pkg::STS_CHKSUM_BIT];
  wire st_abort  = sts_q[ppes_pkg::STS_ABORT_BIT] | evt[ppes_pkg::STS_ABORT_BIT];
  wire st_active = evt[ppes_pkg::STS_ACTIVE_BIT];
  wire st_init   = sts_q[ppes_pkg::STS_INIT_BIT] | evt[ppes_pkg::STS_INIT_BIT];
  wire st_relock = sts_q[ppes_pkg::STS_RELOCK_BIT] | evt[ppes_pkg::STS_RELOCK_BIT];
  wire st_done   = sts_q[ppes_pkg::STS_DONE_BIT] | evt[ppes_pkg::STS_DONE_BIT];

  assign sts_d = {st_chk, st_abort, st_active, st_init, st_relock, st_done};

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [7:0] sts_byte = {2'h0, sts_q};
  wire [7:0] io_byte  = {5'h00, io_level_q};

  assign rdata_d = !reg_rd ? rdata_q
                 : hit_pwr ? pwr_ctrl_q
                 : hit_sts ? sts_byte
                 : hit_io  ? io_byte
                 : ppes_pkg::READ_UNMAPPED;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pwr_ctrl_q <= ppes_pkg::PWR_CTRL_RESET;
      io_level_q <= ppes_pkg::IO_LEVEL_RESET;
      sts_q      <= ppes_pkg::LOAD_STS_RESET;
      rdata_q    <= ppes_pkg::READ_UNMAPPED;
      rvalid_q   <= 1'b0;
    end
    else
    begin
      pwr_ctrl_q <= pwr_ctrl_d;
      io_level_q <= io_level_d;
      sts_q      <= sts_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= reg_rd;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ****************************************************************
  // loop power, reset and level outputs
  // ****************************************************************
  ppes_loop_ctrl u_ppes_loop_ctrl (
    .clock                    (clock),
    .nrst                     (nrst),
    .pwr_ctrl                 (pwr_ctrl_q),
    .io_level                 (io_level_q),
    .system_analog_loop_off   (system_analog_loop_off),
    .system_digital_loop_off  (system_digital_loop_off),
    .second_loop_off          (second_loop_off),
    .first_loop_off           (first_loop_off),
    .first_input_monitor_rst  (first_input_monitor_rst),
    .second_input_monitor_rst (second_input_monitor_rst),
    .system_digital_loop_rst  (system_digital_loop_rst),
    .first_digital_loop_rst   (first_digital_loop_rst),
    .second_digital_loop_rst  (second_digital_loop_rst),
    .serif_clk_from_osc       (serif_clk_from_osc),
    .serif_osc_second         (serif_osc_second),
    .gpio_level_select        (gpio_level_select),
    .serial_out_level_select  (serial_out_level_select)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  wire all_loop_rst = first_input_monitor_rst & second_input_monitor_rst &
                      system_digital_loop_rst & first_digital_loop_rst &
                      second_digital_loop_rst;
  wire any_loop_rst = first_input_monitor_rst | second_input_monitor_rst |
                      system_digital_loop_rst | first_digital_loop_rst |
                      second_digital_loop_rst;

  sysdig_off_a: assert property ((reg_wr && hit_pwr) |-> ##2
    system_digital_loop_off == $past(reg_wdata[ppes_pkg::PWR_SYSDIG_BIT], 2))
    else $error("system digital loop off does not follow its bit");

  second_off_a: assert property (pwr_ctrl_q[ppes_pkg::PWR_SECOND_BIT]
    |=> second_loop_off)
    else $error("second loop not powered down");

  first_off_a: assert property (!pwr_ctrl_q[ppes_pkg::PWR_FIRST_BIT]
    |=> !first_loop_off)
    else $error("first loop powered down with bit clear");

  sysana_off_a: assert property (system_analog_loop_off ==
    $past(pwr_ctrl_q[ppes_pkg::PWR_SYSANA_BIT]))
    else $error("system analog loop off mismatch");

  loop_reset_a: assert property (pwr_ctrl_q[ppes_pkg::PWR_LOOP_RST_BIT]
    |=> all_loop_rst)
    else $error("held blocks not all in reset");

  serif_clk_a: assert property (serif_clk_from_osc ==
    $past(pwr_ctrl_q[ppes_pkg::PWR_SYSANA_BIT]))
    else $error("serial clocks not moved to an oscillator");

  chksum_flag_a: assert property (sts_q[ppes_pkg::STS_CHKSUM_BIT] ==
    $past(evt[ppes_pkg::STS_CHKSUM_BIT]))
    else $error("checksum flag does not track the loader");

  abort_hold_a: assert property (sts_q[ppes_pkg::STS_ABORT_BIT]
    |=> sts_q[ppes_pkg::STS_ABORT_BIT][*3])
    else $error("abort flag dropped");

  active_flag_a: assert property (!evt[ppes_pkg::STS_ACTIVE_BIT]
    |=> !sts_q[ppes_pkg::STS_ACTIVE_BIT])
    else $error("activity flag high with no load");

  active_track_a: assert property (evt[ppes_pkg::STS_ACTIVE_BIT]
    |=> sts_q[ppes_pkg::STS_ACTIVE_BIT])
    else $error("activity flag low during load");

  ready_flag_a: assert property ($rose(sts_q[ppes_pkg::STS_INIT_BIT])
    |-> $past(evt[ppes_pkg::STS_INIT_BIT]))
    else $error("ready flag set without cause");

  relock_flag_a: assert property (evt[ppes_pkg::STS_RELOCK_BIT]
    |=> sts_q[ppes_pkg::STS_RELOCK_BIT])
    else $error("relock flag not set");

  done_flag_a: assert property ($rose(sts_q[ppes_pkg::STS_DONE_BIT])
    |-> $past(evt[ppes_pkg::STS_DONE_BIT]))
    else $error("done flag set without cause");

  gpio_level_a: assert property ((reg_wr && hit_io) |-> ##2
    gpio_level_select == $past(reg_wdata[ppes_pkg::IO_GPIO_BIT], 2))
    else $error("gpio level select mismatch");

  serial_level_a: assert property ((reg_wr && hit_io) |-> ##2
    serial_out_level_select == $past(reg_wdata[ppes_pkg::IO_SERIAL_BIT], 2))
    else $error("serial output level select mismatch");

  sts_nowrite_a: assert property ((reg_wr && hit_sts && sts_q == 6'h00
    && evt == 6'h00) |=> sts_q == 6'h00)
    else $error("status changed by a write");

  reset_release_a: assert property ($fell(pwr_ctrl_q[ppes_pkg::PWR_LOOP_RST_BIT])
    |=> !any_loop_rst)
    else $error("held blocks stay in reset after clear");

  read_answer_a: assert property ((reg_rd && hit_sts) |=>
    (reg_rvalid && reg_rdata == {2'h0, $past(sts_q)}))
    else $error("status read answer wrong");

  second_on_a: assert property (!pwr_ctrl_q[ppes_pkg::PWR_SECOND_BIT]
    |=> !second_loop_off)
    else $error("second loop powered down with bit clear");

  first_on_a: assert property (pwr_ctrl_q[ppes_pkg::PWR_FIRST_BIT]
    |=> first_loop_off)
    else $error("first loop not powered down");

  sysdig_track_a: assert property (system_digital_loop_off ==
    $past(pwr_ctrl_q[ppes_pkg::PWR_SYSDIG_BIT]))
    else $error("system digital loop off does not track its bit");

  loop_run_a: assert property (!pwr_ctrl_q[ppes_pkg::PWR_LOOP_RST_BIT]
    |=> !any_loop_rst)
    else $error("held blocks in reset with bit clear");

  osc_second_a: assert property (serif_osc_second ==
    ($past(pwr_ctrl_q[ppes_pkg::PWR_SYSANA_BIT]) & $past(pwr_ctrl_q[ppes_pkg::PWR_FIRST_BIT])))
    else $error("oscillator choice mismatch");

  abort_set_a: assert property (evt[ppes_pkg::STS_ABORT_BIT]
    |=> sts_q[ppes_pkg::STS_ABORT_BIT])
    else $error("abort flag not set");

  abort_cause_a: assert property ($rose(sts_q[ppes_pkg::STS_ABORT_BIT])
    |-> $past(evt[ppes_pkg::STS_ABORT_BIT]))
    else $error("abort flag set without cause");

  ready_set_a: assert property (evt[ppes_pkg::STS_INIT_BIT]
    |=> sts_q[ppes_pkg::STS_INIT_BIT])
    else $error("ready flag not set");

  relock_cause_a: assert property ($rose(sts_q[ppes_pkg::STS_RELOCK_BIT])
    |-> $past(evt[ppes_pkg::STS_RELOCK_BIT]))
    else $error("relock flag set without cause");

  done_set_a: assert property (evt[ppes_pkg::STS_DONE_BIT]
    |=> sts_q[ppes_pkg::STS_DONE_BIT])
    else $error("done flag not set");

  done_hold_a: assert property (sts_q[ppes_pkg::STS_DONE_BIT]
    |=> sts_q[ppes_pkg::STS_DONE_BIT])
    else $error("done flag dropped");

  pwr_read_a: assert property ((reg_rd && hit_pwr) |=>
    (reg_rvalid && reg_rdata == $past(pwr_ctrl_q)))
    else $error("power control read answer wrong");

  io_read_a: assert property ((reg_rd && hit_io) |=>
    (reg_rvalid && reg_rdata == {5'h00, $past(io_level_q)}))
    else $error("level select read answer wrong");

  unmapped_read_a: assert property ((reg_rd && !hit_pwr && !hit_sts && !hit_io) |=>
    (reg_rvalid && reg_rdata == ppes_pkg::READ_UNMAPPED))
    else $error("unmapped read not zero");

  sts_set_hold_a: assert property (sts_q[ppes_pkg::STS_INIT_BIT]
    |=> sts_q[ppes_pkg::STS_INIT_BIT])
    else $error("ready flag dropped");

  pwr_write_c: cover property (reg_wr && hit_pwr);
  sts_read_c: cover property (reg_rd && hit_sts);
  done_rise_c: cover property ($rose(sts_q[ppes_pkg::STS_DONE_BIT]));
  abort_rise_c: cover property ($rose(sts_q[ppes_pkg::STS_ABORT_BIT]));
  loop_release_c: cover property ($fell(pwr_ctrl_q[ppes_pkg::PWR_LOOP_RST_BIT]));

endmodule

// *** core/ppes_pkg.sv ***
package ppes_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [15:0] PWR_CTRL_OFFSET   = 16'h0011;
  localparam logic [15:0] LOAD_STS_OFFSET   = 16'h0012;
  localparam logic [15:0] IO_LEVEL_OFFSET   = 16'h0013;

  // ****************************************************************
  // general_power_down_ctrl fields
  // ****************************************************************
  localparam int unsigned PWR_UPDATE_BIT    = 0;
  localparam int unsigned PWR_LOOP_RST_BIT  = 1;
  localparam int unsigned PWR_FIRST_BIT     = 2;
  localparam int unsigned PWR_SECOND_BIT    = 3;
  localparam int unsigned PWR_SYSDIG_BIT    = 4;
  localparam int unsigned PWR_SYSANA_BIT    = 5;
  localparam logic [7:0]  PWR_CTRL_RESET    = 8'h00;

  // ****************************************************************
  // eeprom_load_status fields
  // ****************************************************************
  localparam int unsigned STS_DONE_BIT      = 0;
  localparam int unsigned STS_RELOCK_BIT    = 1;
  localparam int unsigned STS_INIT_BIT      = 2;
  localparam int unsigned STS_ACTIVE_BIT    = 3;
  localparam int unsigned STS_ABORT_BIT     = 4;
  localparam int unsigned STS_CHKSUM_BIT    = 5;
  localparam int unsigned STS_WIDTH         = 6;
  localparam logic [5:0]  LOAD_STS_RESET    = 6'h00;

  // ****************************************************************
  // io_voltage_select fields
  // ****************************************************************
  localparam int unsigned IO_SERIAL_BIT     = 0;
  localparam int unsigned IO_GPIO_BIT       = 2;
  localparam int unsigned IO_USED_WIDTH     = 3;
  localparam logic [2:0]  IO_LEVEL_RESET    = 3'h0;

  // ****************************************************************
  // misc
  // ****************************************************************
  localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

endpackage

// *** core/ppes_sync.sv ***
`timescale 1ns/1ps
module ppes_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ****************************************************************
  // two flops per bit; first stage feeds only the second
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic stage1_q;
      logic stage2_q;
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          stage1_q <= 1'b0;
          stage2_q <= 1'b0;
        end
        else
        begin
          stage1_q <= async_in[i];
          stage2_q <= stage1_q;
        end
      end
      assign sync_out[i] = stage2_q;
    end
  endgenerate

endmodule

// *** core/ppes_loop_ctrl.sv ***
`timescale 1ns/1ps
module ppes_loop_ctrl (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [7:0] pwr_ctrl,
  input  wire logic [2:0] io_level,
  output logic            system_analog_loop_off,
  output logic            system_digital_loop_off,
  output logic            second_loop_off,
  output logic            first_loop_off,
  output logic            first_input_monitor_rst,
  output logic            second_input_monitor_rst,
  output logic            system_digital_loop_rst,
  output logic            first_digital_loop_rst,
  output logic            second_digital_loop_rst,
  output logic            serif_clk_from_osc,
  output logic            serif_osc_second,
  output logic            gpio_level_select,
  output logic            serial_out_level_select
);

  // ****************************************************************
  // decoded controls
  // ****************************************************************
  wire loop_block_reset = pwr_ctrl[ppes_pkg::PWR_LOOP_RST_BIT];
  wire ana_off          = pwr_ctrl[ppes_pkg::PWR_SYSANA_BIT];
  // fall back to the second oscillator only if the first loop is off
  wire osc_second       = ana_off & pwr_ctrl[ppes_pkg::PWR_FIRST_BIT];

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      system_analog_loop_off   <= 1'b0;
      system_digital_loop_off  <= 1'b0;
      second_loop_off          <= 1'b0;
      first_loop_off           <= 1'b0;
      first_input_monitor_rst  <= 1'b0;
      second_input_monitor_rst <= 1'b0;
      system_digital_loop_rst  <= 1'b0;
      first_digital_loop_rst   <= 1'b0;
      second_digital_loop_rst  <= 1'b0;
      serif_clk_from_osc       <= 1'b0;
      serif_osc_second         <= 1'b0;
      gpio_level_select        <= 1'b0;
      serial_out_level_select  <= 1'b0;
    end
    else
    begin
      system_analog_loop_off   <= ana_off;
      system_digital_loop_off  <= pwr_ctrl[ppes_pkg::PWR_SYSDIG_BIT];
      second_loop_off          <= pwr_ctrl[ppes_pkg::PWR_SECOND_BIT];
      first_loop_off           <= pwr_ctrl[ppes_pkg::PWR_FIRST_BIT];
      first_input_monitor_rst  <= loop_block_reset;
      second_input_monitor_rst <= loop_block_reset;
      system_digital_loop_rst  <= loop_block_reset;
      first_digital_loop_rst   <= loop_block_reset;
      second_digital_loop_rst  <= loop_block_reset;
      serif_clk_from_osc       <= ana_off;
      serif_osc_second         <= osc_second;
      gpio_level_select        <= io_level[ppes_pkg::IO_GPIO_BIT];
      serial_out_level_select  <= io_level[ppes_pkg::IO_SERIAL_BIT];
    end
  end

endmodule

// *** dv/ppes_regs_test.sv ***
`timescale 1ns/1ps
module ppes_regs_test;
  logic        clock;
  logic        nrst;
  logic [15:0] reg_addr;
  logic        reg_wr, reg_rd, reg_rvalid;
  logic [7:0]  reg_wdata, reg_rdata, p, io;
  logic        cks_in, abt_in, act_in, ini_in, rel_in, don_in;
  logic        sa_off, sd_off, s2_off, s1_off, m1_rst, m2_rst, sd_rst, d1_rst, d2_rst;
  logic        osc_sel, osc_second, gpio_sel, sout_sel;
  logic [5:0]  v, sticky;
  logic [12:0] outs;
  int          err_count;
  int          comparisons;
  int          seed;
  int          cycles;

`define check_eq(act, exp) check_val(32'(act), 32'(exp))

  // ****************************************************************
  // design and clock
  // ****************************************************************
  ppes_regs u_ppes_regs (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .config_checksum_fail_in(cks_in), .config_load_aborted_in(abt_in),
    .config_load_active_in(act_in), .init_finished_in(ini_in),
    .load_relock_init_complete_in(rel_in), .config_load_done_in(don_in),
    .system_analog_loop_off(sa_off), .system_digital_loop_off(sd_off),
    .second_loop_off(s2_off), .first_loop_off(s1_off),
    .first_input_monitor_rst(m1_rst), .second_input_monitor_rst(m2_rst),
    .system_digital_loop_rst(sd_rst), .first_digital_loop_rst(d1_rst),
    .second_digital_loop_rst(d2_rst), .serif_clk_from_osc(osc_sel),
    .serif_osc_second(osc_second), .gpio_level_select(gpio_sel),
    .serial_out_level_select(sout_sel)
  );

  assign outs = {sa_off, sd_off, s2_off, s1_off, m1_rst, m2_rst, sd_rst, d1_rst, d2_rst,
                 osc_sel, osc_second, gpio_sel, sout_sel};

  initial clock = 1'b0;
  always #25 clock = ~clock;

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("timeout after %0d cycles", cycles);
      close_out();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [12:0] exp_outs(input logic [7:0] pw, input logic [7:0] lv);
    exp_outs = {pw[5], pw[4], pw[3], pw[2], {5{pw[1]}}, pw[5], pw[5] & pw[2], lv[2], lv[0]};
  endfunction

  // checksum and active follow the loader, the rest stay set
  function automatic logic [7:0] sts_exp(input logic [5:0] lvl, input logic [5:0] st);
    sts_exp = {2'b00, lvl[5], st[4], lvl[3], st[2], st[1], st[0]};
  endfunction

  task automatic check_val(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic step();
    @(posedge clock);
    #2;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    `check_eq(reg_rvalid, 1'b1);
    `check_eq(reg_rdata, e);
    reg_rd = 1'b0;
    step();
  endtask

  task automatic set_ld(input logic [5:0] d);
    {cks_in, abt_in, act_in, ini_in, rel_in, don_in} = d;
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    seed = 32'h65e0;
    nrst = 1'b0;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    sticky = 6'h00;
    set_ld(6'h00);
    repeat (12) @(posedge clock);
    #2;
    nrst = 1'b1;
    chk_rd(16'h0011, 8'h00);
    chk_rd(16'h0012, 8'h00);
    chk_rd(16'h0013, 8'h00);
    `check_eq(outs, 13'h0000);
    $display("test reset values done");
    for (int i = 0; i < 24; i++)
    begin
      p = (i == 0) ? 8'hff : (i == 1) ? 8'h24 : (i == 2) ? 8'h00 : 8'($random(seed));
      p = p & 8'h3e;
      io = (i == 0) ? 8'hff : 8'($random(seed));
      wr(16'h0011, p);
      wr(16'h0013, io);
      step();
      `check_eq(outs, exp_outs(p, io));
      chk_rd(16'h0011, p);
      chk_rd(16'h0013, io & 8'h07);
    end
    $display("test power and level fields done");
    wr(16'h0011, 8'h02);
    repeat (5) step();
    `check_eq(outs, exp_outs(8'h02, io));
    wr(16'h0011, 8'h00);
    step();
    `check_eq(outs, exp_outs(8'h00, io));
    $display("test loop reset hold done");
    wr(16'h0012, 8'hff);
    wr(16'h0014, 8'hff);
    wr(16'hffff, 8'hff);
    chk_rd(16'h0012, 8'h00);
    chk_rd(16'h0014, 8'h00);
    chk_rd(16'h0011, 8'h00);
    chk_rd(16'h0013, io & 8'h07);
    $display("test refused accesses done");
    reg_addr = 16'h0011;
    reg_wdata = 8'h30;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    step();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    `check_eq(reg_rvalid, 1'b1);
    `check_eq(reg_rdata, 8'h00);
    step();
    `check_eq(outs, exp_outs(8'h30, io));
    chk_rd(16'h0011, 8'h30);
    $display("test simultaneous read and write done");
    set_ld(6'h10);
    repeat (2) step();
    set_ld(6'h00);
    repeat (4) step();
    sticky = 6'h10;
    chk_rd(16'h0012, sts_exp(6'h00, sticky));
    for (int i = 0; i < 16; i++)
    begin
      v = 6'($random(seed));
      set_ld(v);
      repeat (4) step();
      sticky = sticky | v;
      chk_rd(16'h0012, sts_exp(v, sticky));
    end
    $display("test load status done");
    set_ld(6'h00);
    nrst = 1'b0;
    repeat (2) step();
    nrst = 1'b1;
    repeat (3) step();
    chk_rd(16'h0012, 8'h00);
    chk_rd(16'h0011, 8'h00);
    `check_eq(outs, 13'h0000);
    $display("test second reset done");
    close_out();
  end
endmodule
